// ===== shared/prescaler_pkg.sv
/*
 Constants for the two timer prescalers: counter widths, reset values,
 tap positions and the mode-register bits that clear the subclock prescaler.
 Assumes a single 200 MHz clock from which all slower rates are enable pulses.
*/
package prescaler_pkg;
	localparam int sys_width = 13;
	localparam int sub_width = 5;
	localparam logic [12:0] sys_reset_value = 13'h0000;
	localparam logic [4:0] sub_reset_value = 5'h00;
	localparam int tap_count = 8;
	// Counter bit index k-1 for each tap of ratio 2^k, tap 0 is divide by 8192.
	localparam int tap_bit [tap_count] = '{12, 11, 10, 8, 7, 6, 4, 2};
	localparam int sel_width = 3;
	localparam int tbs_bit = 3;
	localparam int cs2_bit = 2;
	localparam int mode_width = 4;
	localparam int period_count = 4;
	localparam int clk_mhz = 200;
endpackage

// ===== rtl/tap_select.sv
/*
 One consumer's tap selector: picks one carry-out pulse of the shared count.
 Assumes the tap pulses are one-cycle and on the same clock.
*/
`timescale 1ns/100ps
module tap_select
	import prescaler_pkg::*;
#(
	parameter int n_taps = tap_count,
	parameter int sel_bits = sel_width
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [n_taps-1:0] taps,
	input wire logic [sel_bits-1:0] sel,
	output logic tick
);
	logic tick_d;
	logic tick_q;

	always_comb
	begin
		tick_d = taps[sel];
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			tick_q <= 1'b0;
		else
			tick_q <= tick_d;
	end

	assign tick = tick_q;
endmodule // tap_select

// ===== rtl/timer_prescalers.sv
/*
 The system clock prescaler and subclock prescaler with their divided taps,
 and per-consumer tap selection for four timers and two serial interfaces.
 Timer A picks its tap from its mode register, or takes the time base instead.
 The block holds no register that software can reach.
 Assumes sys_enable and sub_enable are one-cycle pulses on clk from a divider,
 and the low-power mode flag comes from logic on the same clock.
 Assumes the mode register and every select also come from registers on clk,
 so none of these inputs needs a synchroniser here.
 Assumes each consumer acts on the one-cycle ticks alone.
*/
// Summary of operation
// - System prescaler is a 13-bit counter.
// - It advances by one per system tick.
// - Reset clears it; counts again when active.
// - Low-power modes halt and clear it.
// - Processor cannot read or write it.
// - Six consumers select ratios independently.
// - Taps span divide 8 to 8192.
// - Subclock prescaler is a 5-bit counter.
// - Reset clears it; starts when active.
// - It keeps counting in low-power modes.
// - Mode bits three and two clear it.
// - Subclock over 32 feeds first timer.
`timescale 1ns/100ps
module timer_prescalers
	import prescaler_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic sys_enable,
	input wire logic sub_enable,
	input wire logic low_power,
	input wire logic [mode_width-1:0] first_timer_mode_register,
	input wire logic [sel_width-1:0] timer_b_sel,
	input wire logic [sel_width-1:0] timer_c_sel,
	input wire logic [sel_width-1:0] timer_e_sel,
	input wire logic [sel_width-1:0] serial1_sel,
	input wire logic [sel_width-1:0] serial2_sel,
	output logic timer_a_tick,
	output logic timer_b_tick,
	output logic timer_c_tick,
	output logic timer_e_tick,
	output logic serial1_tick,
	output logic serial2_tick,
	output logic time_base_tick
);
	logic [sys_width-1:0] sys_q;
	logic [sys_width-1:0] sys_d;
	logic [sub_width-1:0] sub_q;
	logic [sub_width-1:0] sub_d;

	logic sys_step;
	logic sub_step;
	logic sub_clear;
	logic time_base_mode;
	logic [sel_width-1:0] interval_sel;
	logic [tap_count-1:0] taps;
	logic tb_d;
	logic tb_q;
	logic ta_d;
	logic ta_q;

	// The count has no bus path at all, so software can never disturb it.
	// A tick only counts while the system clock runs, so low power gates it.
	assign sys_step = sys_enable & ~low_power;
	assign time_base_mode = first_timer_mode_register[tbs_bit];
	assign sub_clear = time_base_mode & first_timer_mode_register[cs2_bit];
	assign sub_step = sub_enable & ~sub_clear;
	assign interval_sel = first_timer_mode_register[sel_width-1:0];

	// Low power wins over a tick, so the count is zero on return to active mode.
	always_comb
	begin
		sys_d = sys_q;
		if (low_power)
		begin
			sys_d = sys_reset_value;
		end
		else if (sys_enable)
		begin
			sys_d = sys_q + 13'h0001;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sys_q <= sys_reset_value;
		end
		else
		begin
			sys_q <= sys_d;
		end
	end

	// Clearing wins over counting, so software always gets a clean restart.
	always_comb
	begin
		sub_d = sub_q;
		if (sub_clear)
		begin
			sub_d = sub_reset_value;
		end
		else if (sub_enable)
		begin
			sub_d = sub_q + 5'h01;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sub_q <= sub_reset_value;
		end
		else
		begin
			sub_q <= sub_d;
		end
	end

	// Each tap is the carry out of its counter bit, so every tap stays in phase.
	always_comb
	begin
		taps[0] = sys_step & (&sys_q[tap_bit[0]:0]);
		taps[1] = sys_step & (&sys_q[tap_bit[1]:0]);
		taps[2] = sys_step & (&sys_q[tap_bit[2]:0]);
		taps[3] = sys_step & (&sys_q[tap_bit[3]:0]);
		taps[4] = sys_step & (&sys_q[tap_bit[4]:0]);
		taps[5] = sys_step & (&sys_q[tap_bit[5]:0]);
		taps[6] = sys_step & (&sys_q[tap_bit[6]:0]);
		taps[7] = sys_step & (&sys_q[tap_bit[7]:0]);
	end

	// The time base is held off while software holds the subclock prescaler clear.
	always_comb
	begin
		tb_d = sub_step & (&sub_q);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			tb_q <= 1'b0;
		end
		else
		begin
			tb_q <= tb_d;
		end
	end

	// The overflow period choice is left to timer A; it only needs the base tick.
	always_comb
	begin
		if (time_base_mode)
		begin
			ta_d = tb_d;
		end
		else
		begin
			ta_d = taps[interval_sel];
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ta_q <= 1'b0;
		end
		else
		begin
			ta_q <= ta_d;
		end
	end

	// Timers B and C simply never use the eighth code in their own logic.
	tap_select u_timer_b (
		.clk(clk),
		.reset(reset),
		.taps(taps),
		.sel(timer_b_sel),
		.tick(timer_b_tick)
	);

	tap_select u_timer_c (
		.clk(clk),
		.reset(reset),
		.taps(taps),
		.sel(timer_c_sel),
		.tick(timer_c_tick)
	);

	tap_select u_timer_e (
		.clk(clk),
		.reset(reset),
		.taps(taps),
		.sel(timer_e_sel),
		.tick(timer_e_tick)
	);

	tap_select u_serial1 (
		.clk(clk),
		.reset(reset),
		.taps(taps),
		.sel(serial1_sel),
		.tick(serial1_tick)
	);

	tap_select u_serial2 (
		.clk(clk),
		.reset(reset),
		.taps(taps),
		.sel(serial2_sel),
		.tick(serial2_tick)
	);

	// Both timer A outputs leave straight from their flip-flops.
	assign timer_a_tick = ta_q;
	assign time_base_tick = tb_q;
endmodule // timer_prescalers

// ===== sim/timer_prescalers_props.sv
/* Tick timing checks for the prescalers.
 Assumes a bind onto timer_prescalers. */
`timescale 1ns/100ps
module timer_prescalers_props
	import prescaler_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic sys_enable,
	input wire logic sub_enable,
	input wire logic low_power,
	input wire logic [mode_width-1:0] first_timer_mode_register,
	input wire logic timer_a_tick,
	input wire logic timer_b_tick,
	input wire logic timer_c_tick,
	input wire logic timer_e_tick,
	input wire logic serial1_tick,
	input wire logic serial2_tick,
	input wire logic time_base_tick
);
	wire ns = low_power | !sys_enable;
	wire nw = !sub_enable | (first_timer_mode_register[3] & first_timer_mode_register[2]);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_b; ns |=> !timer_b_tick; endproperty
	a_b: assert property (p_b) else $error("b tick");
	property p_c; ns |=> !timer_c_tick; endproperty
	a_c: assert property (p_c) else $error("c tick");
	property p_e; ns |=> !timer_e_tick; endproperty
	a_e: assert property (p_e) else $error("e tick");
	property p_s; ns |=> !(serial1_tick | serial2_tick); endproperty
	a_s: assert property (p_s) else $error("serial tick");
	property p_w; nw |=> !time_base_tick; endproperty
	a_w: assert property (p_w) else $error("base tick");
	property p_t; time_base_tick |=> !time_base_tick [*8]; endproperty
	a_t: assert property (p_t) else $error("base period");
	property p_a; $past(first_timer_mode_register[3]) |-> timer_a_tick == time_base_tick; endproperty
	a_a: assert property (p_a) else $error("a source");
	property p_8; timer_b_tick |=> !timer_b_tick; endproperty
	a_8: assert property (p_8) else $error("b twice");
endmodule // timer_prescalers_props

// ===== sim/tick_consumers.sv
/* Timers and serial units as one tick counter.
 Assumes ticks are one-cycle pulses on clk. */
`timescale 1ns/100ps
module tick_consumers
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [6:0] ticks,
	output int seen
);
	always_ff @(posedge clk or posedge reset)
		if (reset)
			seen <= 0;
		else
			seen <= seen + $countones(ticks);
endmodule // tick_consumers

// ===== sim/test_timer_prescalers.sv
/* Random self-checking bench for timer_prescalers.
 Assumes the package is compiled first. */
`timescale 1ns/100ps
module test_timer_prescalers
	import prescaler_pkg::*;
;
	logic clk = 0, reset = 1, sys_en = 0, sub_en = 0, lp = 0, tb;
	logic [3:0] mode = 4'h0;
	logic [2:0] sel [5] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
	wire [6:0] got;
	logic [6:0] exp_q = 7'h00;
	int sys, sub, seed = 32'habf3750b, miscompares, n_tests, n_exp, seen, i;
	function logic tap(int s);
		return sys_en && !lp && (sys & ((2 << tap_bit[s]) - 1)) == (2 << tap_bit[s]) - 1;
	endfunction
	timer_prescalers i_timer_prescalers (.clk(clk), .reset(reset), .sys_enable(sys_en),
		.sub_enable(sub_en), .low_power(lp), .first_timer_mode_register(mode),
		.timer_b_sel(sel[0]), .timer_c_sel(sel[1]), .timer_e_sel(sel[2]), .serial1_sel(sel[3]),
		.serial2_sel(sel[4]), .timer_a_tick(got[6]), .timer_b_tick(got[5]), .timer_c_tick(got[4]),
		.timer_e_tick(got[3]), .serial1_tick(got[2]), .serial2_tick(got[1]),
		.time_base_tick(got[0]));
	tick_consumers i_tick_consumers (.clk(clk), .reset(reset), .ticks(got), .seen(seen));
	initial
		forever #2.5 clk = !clk;
	always @(posedge clk or posedge reset)
		if (reset)
		begin
			exp_q = 7'h00;
			sys = 0;
			sub = 0;
		end
		else
		begin
			tb = sub_en && sub == 31 && !(mode[3] & mode[2]);
			exp_q = {mode[3] ? tb : tap(mode[2:0]), tap(sel[0]), tap(sel[1]), tap(sel[2]),
				tap(sel[3]), tap(sel[4]), tb};
			n_exp += $countones(exp_q);
			sys = lp ? 0 : (sys + sys_en) % 8192;
			sub = (mode[3] & mode[2]) ? 0 : (sub + sub_en) % 32;
		end
	task end_of_test;
		$display("%0d compares, %0d mismatches", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(negedge clk);
		reset = 0;
		for (i = 0; i < 40000; i++)
		begin
			@(negedge clk);
			n_tests++;
			if (got !== exp_q)
			begin
				miscompares++;
				$display("unexpected at %0t: %h vs %h", $time, got, exp_q);
			end
			sys_en = $random(seed) % 8 != 0;
			sub_en = $random(seed) % 2 != 0;
			lp = i % 20000 >= 19900;
			if (i % 2048 == 0)
				mode = 4'($random(seed));
			if (i % 2048 == 0)
				foreach (sel[k]) sel[k] = 3'($random(seed));
		end
		$display("random run done");
		n_tests++;
		if (seen + $countones(got) != n_exp)
		begin
			miscompares++;
			$display("unexpected at %0t: %h vs %h", $time, seen + $countones(got), n_exp);
		end
		end_of_test;
	end
	initial
	begin
		#250000;
		miscompares++;
		end_of_test;
	end
endmodule // test_timer_prescalers
bind timer_prescalers timer_prescalers_props i_props (.clk, .reset, .sys_enable, .sub_enable,
	.low_power, .first_timer_mode_register, .timer_a_tick, .timer_b_tick, .timer_c_tick,
	.timer_e_tick, .serial1_tick, .serial2_tick, .time_base_tick);
